// file: src/input_map_pkg.sv
// Constants for the input terminal function map.
// Assumes a single core clock and an APB register slave.
package input_map_pkg;
    localparam int NUM_TERMINALS = 7;
    localparam int CODE_W = 6;
    localparam int NUM_GENERAL = 16;

    // Assignment codes
    localparam logic [5:0] CODE_NONE = 6'h00;
    localparam logic [5:0] CODE_FORWARD_RUN = 6'h01;
    localparam logic [5:0] CODE_BACKWARD_RUN = 6'h02;
    localparam logic [5:0] CODE_STOP_MODE = 6'h13;
    localparam logic [5:0] CODE_BRAKE_RELEASE = 6'h14;
    localparam logic [5:0] CODE_EXT_FAULT = 6'h15;
    localparam logic [5:0] CODE_REGEN_OVERHEAT = 6'h16;
    localparam logic [5:0] CODE_FAULT_CLEAR = 6'h18;
    localparam logic [5:0] CODE_SETTER_LOCK = 6'h1B;
    localparam logic [5:0] CODE_GENERAL_BASE = 6'h20;
    localparam logic [5:0] CODE_OP_SELECT_BASE = 6'h30;
    localparam logic [5:0] CODE_TORQUE_LIMIT = 6'h36;

    // Reset assignment per terminal, then the network input reset word
    localparam logic [5:0] RESET_CODE_0 = 6'h01;
    localparam logic [5:0] RESET_CODE_1 = 6'h02;
    localparam logic [5:0] RESET_CODE_2 = 6'h13;
    localparam logic [5:0] RESET_CODE_3 = 6'h30;
    localparam logic [5:0] RESET_CODE_4 = 6'h18;
    localparam logic [5:0] RESET_CODE_5 = 6'h14;
    localparam logic [5:0] RESET_CODE_6 = 6'h16;
    localparam logic [31:0] RESET_NET_INPUT = 32'h0000_0180;

    // APB byte addresses
    localparam logic [7:0] ADDR_ASSIGN_BASE = 8'h00;
    localparam logic [7:0] ADDR_ASSIGN_LAST = 8'h18;
    localparam logic [7:0] ADDR_NET_INPUT = 8'h20;
    localparam logic [7:0] ADDR_FUNC_STATUS = 8'h24;
    localparam logic [7:0] ADDR_GENERAL = 8'h28;
    localparam logic [7:0] ADDR_PIN_STATUS = 8'h2C;

    // Network input and function status bit positions
    localparam int BIT_FORWARD_RUN = 0;
    localparam int BIT_BACKWARD_RUN = 1;
    localparam int BIT_STOP_MODE = 2;
    localparam int BIT_BRAKE_RELEASE = 3;
    localparam int BIT_EXT_FAULT = 4;
    localparam int BIT_REGEN_OVERHEAT = 5;
    localparam int BIT_FAULT_CLEAR = 6;
    localparam int BIT_SETTER_LOCK = 7;
    localparam int BIT_TORQUE_LIMIT = 8;
    localparam int BIT_OP_SELECT = 12;
    localparam int BIT_GENERAL = 16;
    localparam int NET_W = 32;
endpackage

// file: src/pin_sync.sv
// Two flip-flop synchroniser for one input pin.
// Assumes the pin is asynchronous to CORE_CLK.
module pin_sync (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pin,
    output logic sync
);
    logic stage1;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= 1'b0;
            sync <= 1'b0;
        end else begin
            stage1 <= pin;
            sync <= stage1;
        end
    end
endmodule

// file: src/code_decode.sv
// Decodes one terminal's assignment code into a one-hot hit per function.
// Assumes the terminal level is already synchronised.
module code_decode (
    input wire logic [5:0] code,
    input wire logic level,
    output logic hit_fwd,
    output logic hit_bwd,
    output logic hit_stop,
    output logic hit_brake,
    output logic hit_fault,
    output logic hit_heat,
    output logic hit_clear,
    output logic is_lock,
    output logic is_tlim,
    output logic [3:0] hit_op,
    output logic [15:0] hit_gen,
    output logic [3:0] is_op_any
);
    wire is_gen = code[5:4] == 2'h2;
    wire is_op = (code[5:4] == 2'h3) && (code[3:2] == 2'h0);

    // Code 0 and unlisted codes match nothing
    assign hit_fwd = level && (code == input_map_pkg::CODE_FORWARD_RUN);
    assign hit_bwd = level && (code == input_map_pkg::CODE_BACKWARD_RUN);
    assign hit_stop = level && (code == input_map_pkg::CODE_STOP_MODE);
    assign hit_brake = level && (code == input_map_pkg::CODE_BRAKE_RELEASE);
    assign hit_fault = level && (code == input_map_pkg::CODE_EXT_FAULT);
    assign hit_heat = level && (code == input_map_pkg::CODE_REGEN_OVERHEAT);
    assign hit_clear = level && (code == input_map_pkg::CODE_FAULT_CLEAR);
    assign is_lock = code == input_map_pkg::CODE_SETTER_LOCK;
    assign is_tlim = code == input_map_pkg::CODE_TORQUE_LIMIT;

    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_gen
            assign hit_gen[i] = level && is_gen && (code[3:0] == 4'(i));
        end
        for (i = 0; i < 4; i++) begin : g_op
            assign is_op_any[i] = is_op && (code[1:0] == 2'(i));
            assign hit_op[i] = level && is_op_any[i];
        end
    endgenerate
endmodule

// file: src/input_terminal_function_map.sv
// Input terminal function map with APB register slave.
// Assumes terminal pins are asynchronous and APB runs on CORE_CLK.
// Operation
// R1 - Each of seven terminals routes to one function via its code.
// R2 - Code 0 ignores the terminal entirely.
// R3 - Code 1 routes to forward run.
// R4 - Code 2 routes to backward run.
// R5 - Code 19 routes to stop style select.
// R6 - Code 20 routes to brake release.
// R7 - Code 21 routes to external fault stop, normally closed.
// R8 - Code 24 routes to fault clear.
// R9 - Code 27 routes to normally closed setter lock release.
// R10 - Codes 48 to 51 form the four operation select bits.
// R11 - Code 54 routes to normally closed torque limit disable.
// R12 - Same functions also come from network inputs.
// R13 - Assignment codes are writable and applied as written.
// R14 - Codes 32 to 47 drive sixteen general bits, readable only.
// R15 - Reset codes are 1, 2, 19, 48, 24, 20, 22.
// R16 - A function on several terminals is active if any is.
// R17 - Fault clear pulses when its input goes active to inactive.
// R18 - Lock and torque inputs idle active; several need all active.
// R19 - Terminal inputs pass two flip-flops before mapping.
//
// The APB register port and the register offsets were left to the implementer.
module input_terminal_function_map (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic [6:0] INPUT_PIN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic FORWARD_RUN,
    output logic BACKWARD_RUN,
    output logic STOP_MODE,
    output logic BRAKE_RELEASE,
    output logic EXTERNAL_FAULT_STOP,
    output logic REGEN_OVERHEAT_SENSE,
    output logic FAULT_CLEAR,
    output logic SETTER_LOCK_RELEASE,
    output logic TORQUE_LIMIT_DISABLE,
    output logic [3:0] OP_SELECT,
    output logic [15:0] GENERAL_BITS
);
    localparam int N = input_map_pkg::NUM_TERMINALS;

    logic [6:0] pin_level;
    logic [5:0] code [0:6];
    logic [31:0] net_input;
    logic clear_prev;

    logic [6:0] t_fwd, t_bwd, t_stop, t_brake, t_fault, t_heat, t_clear;
    logic [6:0] t_lock_sel, t_tlim_sel;
    logic [3:0] t_op [0:6];
    logic [15:0] t_gen [0:6];

    // Per terminal synchroniser and decoder
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_term
            // Each terminal synchronised first [R19]
            pin_sync u_sync (
                .clk(CORE_CLK),
                .rst_b(RST_B),
                .pin(INPUT_PIN[i]),
                .sync(pin_level[i])
            );
            // Per terminal decode of its code [R1] [R2]
            code_decode u_dec (
                .code(code[i]),
                .level(pin_level[i]),
                .hit_fwd(t_fwd[i]),
                .hit_bwd(t_bwd[i]),
                .hit_stop(t_stop[i]),
                .hit_brake(t_brake[i]),
                .hit_fault(t_fault[i]),
                .hit_heat(t_heat[i]),
                .hit_clear(t_clear[i]),
                .is_lock(t_lock_sel[i]),
                .is_tlim(t_tlim_sel[i]),
                .hit_op(t_op[i]),
                .hit_gen(t_gen[i]),
                .is_op_any()
            );
        end
    endgenerate

    // Combine terminals with OR [R16]
    wire any_fwd = |t_fwd;
    wire any_bwd = |t_bwd;
    wire any_stop = |t_stop;
    wire any_brake = |t_brake;
    wire any_fault = |t_fault;
    wire any_heat = |t_heat;
    wire any_clear = |t_clear;
    logic [3:0] acc_op [0:N];
    logic [15:0] acc_gen [0:N];
    assign acc_op[0] = 4'h0;
    assign acc_gen[0] = 16'h0000;
    generate
        for (i = 0; i < N; i++) begin : g_any
            assign acc_op[i + 1] = acc_op[i] | t_op[i];
            assign acc_gen[i + 1] = acc_gen[i] | t_gen[i];
        end
    endgenerate
    wire [3:0] any_op = acc_op[N];
    wire [15:0] any_gen = acc_gen[N];

    // Unassigned lock terminals count as active, so AND holds [R18]
    wire pins_lock = &(~t_lock_sel | pin_level);
    wire pins_tlim = &(~t_tlim_sel | pin_level);

    // Network inputs merge with direct terminals [R12]
    wire next_fwd = any_fwd | net_input[input_map_pkg::BIT_FORWARD_RUN];
    wire next_bwd = any_bwd | net_input[input_map_pkg::BIT_BACKWARD_RUN];
    wire next_stop = any_stop | net_input[input_map_pkg::BIT_STOP_MODE];
    wire next_brake = any_brake
        | net_input[input_map_pkg::BIT_BRAKE_RELEASE];
    wire next_fault = any_fault | net_input[input_map_pkg::BIT_EXT_FAULT];
    wire next_heat = any_heat
        | net_input[input_map_pkg::BIT_REGEN_OVERHEAT];
    wire clear_level = any_clear
        | net_input[input_map_pkg::BIT_FAULT_CLEAR];
    // Lock functions need every source active [R9] [R11] [R18]
    wire next_lock = pins_lock & net_input[input_map_pkg::BIT_SETTER_LOCK];
    wire next_tlim = pins_tlim
        & net_input[input_map_pkg::BIT_TORQUE_LIMIT];
    wire [3:0] next_op = any_op
        | net_input[input_map_pkg::BIT_OP_SELECT +: 4];
    wire [15:0] next_gen = any_gen
        | net_input[input_map_pkg::BIT_GENERAL +: 16];
    // Falling edge of fault clear gives one pulse [R17]
    wire next_clear = clear_prev & ~clear_level;

    // APB decode
    wire apb_access = PSEL && PENABLE;
    wire setup_phase = PSEL && !PENABLE;
    wire is_assign = (PADDR >= input_map_pkg::ADDR_ASSIGN_BASE)
        && (PADDR <= input_map_pkg::ADDR_ASSIGN_LAST)
        && (PADDR[1:0] == 2'h0);
    wire [2:0] assign_idx = PADDR[4:2];
    wire is_net = PADDR == input_map_pkg::ADDR_NET_INPUT;
    wire is_status = PADDR == input_map_pkg::ADDR_FUNC_STATUS;
    wire is_general = PADDR == input_map_pkg::ADDR_GENERAL;
    wire is_pins = PADDR == input_map_pkg::ADDR_PIN_STATUS;
    wire is_mapped = is_assign || is_net || is_status || is_general
        || is_pins;
    // Write strobes per register
    wire wr_en = apb_access && PWRITE && is_assign;
    wire wr_net = apb_access && PWRITE && is_net;

    // Status word uses the network bit positions
    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[input_map_pkg::BIT_FORWARD_RUN] = FORWARD_RUN;
        status_word[input_map_pkg::BIT_BACKWARD_RUN] = BACKWARD_RUN;
        status_word[input_map_pkg::BIT_STOP_MODE] = STOP_MODE;
        status_word[input_map_pkg::BIT_BRAKE_RELEASE] = BRAKE_RELEASE;
        status_word[input_map_pkg::BIT_EXT_FAULT] = EXTERNAL_FAULT_STOP;
        status_word[input_map_pkg::BIT_REGEN_OVERHEAT] = REGEN_OVERHEAT_SENSE;
        status_word[input_map_pkg::BIT_FAULT_CLEAR] = FAULT_CLEAR;
        status_word[input_map_pkg::BIT_SETTER_LOCK] = SETTER_LOCK_RELEASE;
        status_word[input_map_pkg::BIT_TORQUE_LIMIT] = TORQUE_LIMIT_DISABLE;
        status_word[input_map_pkg::BIT_OP_SELECT +: 4] = OP_SELECT;
    end

    // Read words for the code and pin registers
    wire [31:0] code_word = {26'h0, code[assign_idx]};
    wire [31:0] pin_word = {25'h0, pin_level};
    // Read mux, unmapped addresses read zero
    wire [31:0] next_rdata;
    assign next_rdata = !is_mapped ? 32'h0000_0000
        : is_assign ? code_word
        : is_net ? net_input
        : is_status ? status_word
        : is_general ? {16'h0000, GENERAL_BITS}
        : pin_word;

    // Reset assignment per terminal [R15]
    wire [5:0] reset_code [0:6];
    assign reset_code[0] = input_map_pkg::RESET_CODE_0;
    assign reset_code[1] = input_map_pkg::RESET_CODE_1;
    assign reset_code[2] = input_map_pkg::RESET_CODE_2;
    assign reset_code[3] = input_map_pkg::RESET_CODE_3;
    assign reset_code[4] = input_map_pkg::RESET_CODE_4;
    assign reset_code[5] = input_map_pkg::RESET_CODE_5;
    assign reset_code[6] = input_map_pkg::RESET_CODE_6;

    generate
        for (i = 0; i < N; i++) begin : g_code
            // Written code takes effect at once [R13] [R15]
            always_ff @(posedge CORE_CLK or negedge RST_B) begin
                if (!RST_B) begin
                    code[i] <= reset_code[i];
                end else if (wr_en && (assign_idx == 3'(i))) begin
                    code[i] <= PWDATA[5:0];
                end
            end
        end
    endgenerate

    // Network word; lock bits idle active [R12] [R18]
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            net_input <= input_map_pkg::RESET_NET_INPUT;
        end else if (wr_net) begin
            net_input <= PWDATA;
        end
    end

    // Read data captured in the setup cycle and held
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            PRDATA <= 32'h0000_0000;
        end else if (setup_phase) begin
            PRDATA <= next_rdata;
        end
    end

    // Every access ends after one cycle [R13]
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            PREADY <= 1'b0;
        end else begin
            PREADY <= setup_phase;
        end
    end

    // Unmapped addresses answer with an error
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            PSLVERR <= 1'b0;
        end else begin
            PSLVERR <= setup_phase && !is_mapped;
        end
    end

    // Forward run [R3]
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            FORWARD_RUN <= 1'b0;
        end else begin
            FORWARD_RUN <= next_fwd;
        end
    end

    // Backward run [R4]
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            BACKWARD_RUN <= 1'b0;
        end else begin
            BACKWARD_RUN <= next_bwd;
        end
    end

    // Stop style select [R5]
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            STOP_MODE <= 1'b0;
        end else begin
            STOP_MODE <= next_stop;
        end
    end

    // Brake release [R6]
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            BRAKE_RELEASE <= 1'b0;
        end else begin
            BRAKE_RELEASE <= next_brake;
        end
    end

    // External fault stop, high while contact closed [R7]
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            EXTERNAL_FAULT_STOP <= 1'b0;
        end else begin
            EXTERNAL_FAULT_STOP <= next_fault;
        end
    end

    // Regeneration overheat sense [R15]
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            REGEN_OVERHEAT_SENSE <= 1'b0;
        end else begin
            REGEN_OVERHEAT_SENSE <= next_heat;
        end
    end

    // Fault clear pulse [R8] [R17]
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            FAULT_CLEAR <= 1'b0;
        end else begin
            FAULT_CLEAR <= next_clear;
        end
    end

    // Idle level of fault clear is low, so no false edge [R17]
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            clear_prev <= 1'b0;
        end else begin
            clear_prev <= clear_level;
        end
    end

    // Setter lock release [R9]
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            SETTER_LOCK_RELEASE <= 1'b0;
        end else begin
            SETTER_LOCK_RELEASE <= next_lock;
        end
    end

    // Torque limit disable [R11]
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            TORQUE_LIMIT_DISABLE <= 1'b0;
        end else begin
            TORQUE_LIMIT_DISABLE <= next_tlim;
        end
    end

    // Operation select bits [R10]
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            OP_SELECT <= 4'h0;
        end else begin
            OP_SELECT <= next_op;
        end
    end

    // General bits [R14]
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            GENERAL_BITS <= 16'h0000;
        end else begin
            GENERAL_BITS <= next_gen;
        end
    end
endmodule

// file: verif/input_terminal_function_map_sva.sv
// Checker for the APB slave and output timing of the terminal map.
// Assumes it is bound to the top module and sees its ports only.
module input_map_sva (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic [6:0] INPUT_PIN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic FORWARD_RUN,
    input wire logic FAULT_CLEAR,
    input wire logic [3:0] OP_SELECT
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] up;
    wire bad_addr = PADDR[1:0] != 2'h0 || PADDR > 8'h2C || PADDR == 8'h1C;
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) up <= 3'h0;
        else if (up != 3'h4) up <= up + 3'h1;
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    sequence quiet_s;
        up == 3'h4 && $stable(INPUT_PIN) && !(PSEL && PWRITE);
    endsequence
    ready_after_setup_a:
        assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready");
    ready_one_cycle_a:
        assert property (PREADY |=> !PREADY) else $error("ready too long");
    ready_needs_sel_a:
        assert property (!PSEL |=> !PREADY) else $error("ready while idle");
    err_needs_ready_a:
        assert property (PSLVERR |-> PREADY) else $error("lone error");
    err_on_unmapped_a:
        assert property (PREADY |-> PSLVERR == bad_addr)
        else $error("wrong error response");
    err_reads_zero_a:
        assert property (PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0)
        else $error("refused read not zero");
    rdata_holds_a:
        assert property (!(PSEL && !PENABLE) |=> $stable(PRDATA))
        else $error("read data moved");
    clear_one_cycle_a:
        assert property (FAULT_CLEAR |=> !FAULT_CLEAR)
        else $error("long clear");
    outputs_hold_a:
        assert property (quiet_s [*3] |=> $stable(FORWARD_RUN)
            && $stable(OP_SELECT)) else $error("output moved without cause");
    cover property (PREADY && PWRITE);
    cover property (PREADY && PSLVERR);
    cover property (FAULT_CLEAR);
endmodule
bind input_terminal_function_map input_map_sva i_sva (
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .INPUT_PIN(INPUT_PIN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .FORWARD_RUN(FORWARD_RUN),
    .FAULT_CLEAR(FAULT_CLEAR), .OP_SELECT(OP_SELECT));

// file: verif/switch_bank.sv
// Bank of contact switches that drive the seven input terminals.
// Assumes the bench names the wanted levels; contacts move after an edge.
module switch_bank (
    input wire logic clk,
    input wire logic [6:0] want,
    output logic [6:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pins = 7'h00;
    // Terminal levels set by the outside party
    always @(posedge clk) pins <= want;
endmodule

// file: verif/input_terminal_function_map_bench.sv
// Self-checking bench for the input terminal function map.
// Assumes wait-free APB answers and a switch bank on the terminals.
module input_terminal_function_map_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q, lo;
    logic pready, pslverr, forward_run, lock, clr, e;
    logic [6:0] want = 7'h00;
    logic [6:0] pins;
    logic [7:0] a;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    int cnt;
    logic [5:0] rc [7] = '{6'h01, 6'h02, 6'h13, 6'h30, 6'h18, 6'h14, 6'h16};
    logic [5:0] tc [15] = '{6'h00, 6'h01, 6'h02, 6'h13, 6'h14, 6'h15, 6'h16,
        6'h1B, 6'h36, 6'h30, 6'h31, 6'h32, 6'h33, 6'h20, 6'h2F};
    logic [15:0] th [15] = '{16'h180, 16'h181, 16'h182, 16'h184, 16'h188,
        16'h190, 16'h1A0, 16'h180, 16'h180, 16'h1180, 16'h2180, 16'h4180,
        16'h8180, 16'h1, 16'h8000};
    switch_bank i_sw (.clk(clk), .want(want), .pins(pins));
    input_terminal_function_map i_dut (.CORE_CLK(clk), .RST_B(rst_b),
        .INPUT_PIN(pins), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .FORWARD_RUN(forward_run), .BACKWARD_RUN(), .STOP_MODE(),
        .BRAKE_RELEASE(), .EXTERNAL_FAULT_STOP(), .REGEN_OVERHEAT_SENSE(),
        .FAULT_CLEAR(clr), .SETTER_LOCK_RELEASE(lock),
        .TORQUE_LIMIT_DISABLE(), .OP_SELECT(), .GENERAL_BITS());
    initial forever #50 clk = ~clk;
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, s);
        n_checks++;
        if (s !== x) begin
            $display("MISMATCH %s expected %h seen %h", nm, x, s);
            n_fail++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] ad,
        input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        chk("answer cycles", 32'h1, n);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
        chk("write error", 1'b0, e);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] x);
        apb(1'b0, ad, 32'h0);
        chk($sformatf("read %h", ad), x, q);
        chk("read error", 1'b0, e);
    endtask
    task automatic watch(input string nm, input logic [31:0] x);
        cnt = 0;
        repeat (8) begin
            @(posedge clk);
            if (clr === 1'b1) cnt++;
        end
        chk(nm, x, 32'(cnt));
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 7; i++) rd(8'(i * 4), {26'h0, rc[i]});
        rd(8'h24, 32'h180);
        rd(8'h20, 32'h180);
        for (int i = 1; i < 7; i++) wr(8'(i * 4), 32'h0);
        for (int i = 0; i < 15; i++) begin
            a = tc[i][5:4] == 2'h2 ? 8'h28 : 8'h24;
            lo = a == 8'h28 ? 32'h0 : tc[i] == 6'h1B ? 32'h100 :
                tc[i] == 6'h36 ? 32'h080 : 32'h180;
            wr(8'h00, {26'h0, tc[i]});
            want <= 7'h01;
            repeat (6) @(posedge clk);
            rd(a, {16'h0, th[i]});
            want <= 7'h00;
            repeat (6) @(posedge clk);
            rd(a, lo);
        end
        wr(8'h00, 32'h1);
        wr(8'h04, 32'h1);
        want <= 7'h02;
        repeat (6) @(posedge clk);
        chk("forward run", 1'b1, forward_run);
        wr(8'h00, 32'h1B);
        wr(8'h04, 32'h1B);
        want <= 7'h01;
        repeat (6) @(posedge clk);
        chk("lock one of two", 1'b0, lock);
        want <= 7'h03;
        repeat (6) @(posedge clk);
        chk("lock both", 1'b1, lock);
        rd(8'h2C, 32'h3);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h18);
        want <= 7'h01;
        watch("clear on rise", 32'h0);
        want <= 7'h00;
        watch("clear on fall", 32'h1);
        wr(8'h00, 32'h0);
        wr(8'h20, 32'h181);
        repeat (2) @(posedge clk);
        chk("network forward", 1'b1, forward_run);
        rd(8'h20, 32'h181);
        wr(8'h20, 32'h180);
        foreach (rc[i]) begin
            apb(i[0], 8'h19 + 8'(i), 32'h0);
            chk("refused", 1'b1, e);
            chk("refused data", 32'h0, i[0] ? 32'h0 : q);
        end
        wr(8'h24, 32'hFFFFFFFF);
        rd(8'h24, 32'h180);
        wr(8'h04, 32'hFFFFFFC1);
        rd(8'h04, 32'h1);
        test_done();
    end
endmodule
